// [hdl/asf_filter_ctrl.sv]
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module asf_filter_ctrl (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Register port
	input  wire logic [31:0]      regAddr,
	input  wire logic [15:0]      regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [15:0]      regRdata,
	// System state
	input  wire logic             lowPower,
	input  wire logic             curEnable,
	input  wire logic             vtEnable,
	// To the converters
	output logic                  convReset,
	output asf_pkg::asf_cfg_t     filterCfg,
	output logic                  modTick,
	output logic                  resultStrobe,
	output logic                  resultSettled
);

	logic [15:0]           ctrlReg;
	asf_pkg::asf_state_t   state;
	asf_pkg::asf_state_t   next_state;
	logic [25:0]           phaseAcc;
	logic [26:0]           next_phase;
	logic [19:0]           periodCnt;
	logic [19:0]           period;
	logic [13:0]           warmCnt;
	logic [13:0]           warmNeed;
	logic [2:0]            settleCnt;
	logic [2:0]            settleNeed;
	logic                  ctrlWrite;
	logic                  ctrlChange;
	logic                  chopOn;
	logic                  runAvgOn;
	logic [5:0]            afVal;
	logic [6:0]            sfVal;
	logic                  badPair;
	logic                  anyEnabled;
	logic [15:0]           statusWord;
	logic [19:0]           basePeriod;
	logic [19:0]           avgPeriod;

	assign ctrlWrite  = regWr && (regAddr == asf_pkg::FILTER_CTRL_ADDR);
	assign ctrlChange = ctrlWrite && (regWdata != ctrlReg);
	assign chopOn     = ctrlReg[asf_pkg::CHOP_BIT];
	assign runAvgOn   = ctrlReg[asf_pkg::RUNAVG_BIT] | chopOn;
	assign afVal      = ctrlReg[asf_pkg::AF_LSB +: asf_pkg::AF_WIDTH];
	assign sfVal      = ctrlReg[asf_pkg::SF_LSB +: asf_pkg::SF_WIDTH];
	assign anyEnabled = curEnable | vtEnable;

	// Control register; a write that changes it restarts everything downstream
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrlReg <= asf_pkg::FILTER_CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrlReg <= regWdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			convReset <= 1'b0;
		end else begin
			convReset <= ctrlChange;
		end
	end

	// Effective configuration seen by the datapath
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			filterCfg <= '0;
		end else begin
			filterCfg.chop                  <= chopOn;
			filterCfg.runningAverage        <= runAvgOn;
			filterCfg.averaging_factor      <= afVal;
			filterCfg.second_notch          <= ctrlReg[asf_pkg::NOTCH_BIT];
			filterCfg.decimation_ratio_code <= sfVal;
		end
	end

	// Pairing check; illegal pairs are flagged only, never blocked
	always_comb begin
		badPair = 1'b0;
		if (sfVal >= asf_pkg::SF_LIMIT_HIGH) begin
			badPair = (afVal != 6'h00);
		end else if (sfVal >= asf_pkg::SF_LIMIT_MID) begin
			badPair = (afVal > asf_pkg::AF_LIMIT_MID);
		end
	end

	// Output period in modulator ticks
	always_comb begin
		basePeriod = 20'(({13'h0000, sfVal} + 20'h00001) * 20'(asf_pkg::DECIM_UNIT));
		avgPeriod  = 20'(basePeriod * (20'(afVal) + 20'(asf_pkg::AF_OFFSET)));
		if (sfVal == asf_pkg::SF_FORCE60) begin
			period = asf_pkg::PERIOD_60;
		end else if (sfVal == asf_pkg::SF_FORCE50) begin
			period = asf_pkg::PERIOD_50;
		end else if (afVal != 6'h00) begin
			period = avgPeriod;
		end else if (chopOn) begin
			period = 20'(avgPeriod + 20'(asf_pkg::CHOP_EXTRA));
		end else begin
			period = basePeriod;
		end
	end

	// Settling length in output periods
	always_comb begin
		if (chopOn) begin
			settleNeed = asf_pkg::SETTLE_CHOP;
		end else if (afVal != 6'h00) begin
			settleNeed = runAvgOn ? asf_pkg::SETTLE_AF_RUNAVG : asf_pkg::SETTLE_AF;
		end else begin
			settleNeed = runAvgOn ? asf_pkg::SETTLE_RUNAVG : asf_pkg::SETTLE_PLAIN;
		end
	end

	// Modulator tick by phase accumulation, since 40 MHz is no integer multiple
	always_comb begin
		next_phase = {1'b0, phaseAcc} + {1'b0, (lowPower ? asf_pkg::LP_STEP
			: asf_pkg::MOD_STEP)};
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phaseAcc <= '0;
			modTick  <= 1'b0;
		end else if (next_phase >= {1'b0, asf_pkg::REF_CLK_MOD}) begin
			phaseAcc <= 26'(next_phase - {1'b0, asf_pkg::REF_CLK_MOD});
			modTick  <= 1'b1;
		end else begin
			phaseAcc <= next_phase[25:0];
			modTick  <= 1'b0;
		end
	end

	// Start-up delay scales with the number of enabled converters
	assign warmNeed = (curEnable && vtEnable) ? {asf_pkg::WARM_CYCLES, 1'b0}
		: {1'b0, asf_pkg::WARM_CYCLES};

	always_comb begin
		next_state = state;
		unique case (state)
			asf_pkg::ST_IDLE: begin
				if (anyEnabled) begin
					next_state = asf_pkg::ST_WARM;
				end
			end
			asf_pkg::ST_WARM: begin
				if (!anyEnabled) begin
					next_state = asf_pkg::ST_IDLE;
				end else if (warmCnt >= warmNeed - 14'h0001) begin
					next_state = asf_pkg::ST_RUN;
				end
			end
			asf_pkg::ST_RUN: begin
				if (!anyEnabled) begin
					next_state = asf_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = asf_pkg::ST_IDLE;
			end
		endcase
		if (ctrlChange) begin
			next_state = anyEnabled ? asf_pkg::ST_WARM : asf_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= asf_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			warmCnt <= '0;
		end else if (ctrlChange || state != asf_pkg::ST_WARM) begin
			warmCnt <= '0;
		end else begin
			warmCnt <= 14'(warmCnt + 14'h0001);
		end
	end

	// Output period counter; wraps even if a new period is shorter than the count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			periodCnt    <= '0;
			resultStrobe <= 1'b0;
		end else if (ctrlChange || state != asf_pkg::ST_RUN) begin
			periodCnt    <= '0;
			resultStrobe <= 1'b0;
		end else if (modTick && periodCnt >= period - 20'h00001) begin
			periodCnt    <= '0;
			resultStrobe <= 1'b1;
		end else begin
			periodCnt    <= modTick ? 20'(periodCnt + 20'h00001) : periodCnt;
			resultStrobe <= 1'b0;
		end
	end

	// Settled once the needed number of periods has passed
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			settleCnt     <= '0;
			resultSettled <= 1'b0;
		end else if (ctrlChange || state != asf_pkg::ST_RUN) begin
			settleCnt     <= '0;
			resultSettled <= 1'b0;
		end else if (resultStrobe && !resultSettled) begin
			settleCnt <= 3'(settleCnt + 3'h1);
			if (3'(settleCnt + 3'h1) >= settleNeed) begin
				resultSettled <= 1'b1;
			end
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[asf_pkg::ST_SETTLED_BIT] = resultSettled;
		statusWord[asf_pkg::ST_RUNAVG_BIT]  = runAvgOn;
		statusWord[asf_pkg::ST_BADPAIR_BIT] = badPair;
		statusWord[asf_pkg::ST_RUN_BIT]     = (state == asf_pkg::ST_RUN);
		statusWord[asf_pkg::ST_WARM_BIT]    = (state == asf_pkg::ST_WARM);
	end

	// Read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regRdata <= '0;
		end else if (regRd && regAddr == asf_pkg::FILTER_CTRL_ADDR) begin
			regRdata <= ctrlReg;
		end else if (regRd && regAddr == asf_pkg::FILTER_STAT_ADDR) begin
			regRdata <= statusWord;
		end else begin
			regRdata <= '0;
		end
	end

endmodule

// [inc/asf_pkg.sv]
package asf_pkg;

	// Register map, byte addresses
	localparam logic [31:0] FILTER_CTRL_ADDR  = 32'hffff0518;
	localparam logic [31:0] FILTER_STAT_ADDR  = 32'hffff0530;
	localparam logic [15:0] FILTER_CTRL_RESET = 16'h0007;

	// Field positions in the filter control register
	localparam int CHOP_BIT     = 15;
	localparam int RUNAVG_BIT   = 14;
	localparam int AF_LSB       = 8;
	localparam int AF_WIDTH     = 6;
	localparam int NOTCH_BIT    = 7;
	localparam int SF_LSB       = 0;
	localparam int SF_WIDTH     = 7;

	// Field positions in the status register
	localparam int ST_SETTLED_BIT = 0;
	localparam int ST_RUNAVG_BIT  = 1;
	localparam int ST_BADPAIR_BIT = 2;
	localparam int ST_RUN_BIT     = 3;
	localparam int ST_WARM_BIT    = 4;

	// Clocks and rates
	localparam int          REF_CLK_HZ = 40_000_000;
	localparam logic [25:0] REF_CLK_MOD = 26'(REF_CLK_HZ);
	localparam int          MOD_HZ     = 512_000;
	localparam int          LP_MOD_HZ  = 131_000;
	localparam logic [25:0] MOD_STEP   = 26'(MOD_HZ);
	localparam logic [25:0] LP_STEP    = 26'(LP_MOD_HZ);

	// Output period figures, in modulator ticks
	localparam int          DECIM_UNIT  = 64;
	localparam int          AF_OFFSET   = 3;
	localparam int          CHOP_EXTRA  = 3;
	localparam logic [6:0]  SF_FORCE60  = 7'h7e;
	localparam logic [6:0]  SF_FORCE50  = 7'h7f;
	localparam int          FORCE60_HZ  = 60;
	localparam int          FORCE50_HZ  = 50;
	localparam logic [19:0] PERIOD_60   = 20'(MOD_HZ / FORCE60_HZ);
	localparam logic [19:0] PERIOD_50   = 20'(MOD_HZ / FORCE50_HZ);

	// Settling, in output periods
	localparam logic [2:0] SETTLE_PLAIN      = 3'h3;
	localparam logic [2:0] SETTLE_RUNAVG     = 3'h4;
	localparam logic [2:0] SETTLE_AF         = 3'h1;
	localparam logic [2:0] SETTLE_AF_RUNAVG  = 3'h2;
	localparam logic [2:0] SETTLE_CHOP       = 3'h2;

	// Pairing limits of decimation against averaging
	localparam logic [6:0] SF_LIMIT_MID  = 7'h20;
	localparam logic [6:0] SF_LIMIT_HIGH = 7'h40;
	localparam logic [5:0] AF_LIMIT_MID  = 6'h07;

	// Start-up delay per enabled converter
	localparam int          WARM_US      = 60;
	localparam logic [12:0] WARM_CYCLES  =
		13'((WARM_US * 64'(REF_CLK_HZ) + 64'd999_999) / 64'd1_000_000);

	typedef struct packed {
		logic       chop;
		logic       runningAverage;
		logic [5:0] averaging_factor;
		logic       second_notch;
		logic [6:0] decimation_ratio_code;
	} asf_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WARM = 3'b010,
		ST_RUN  = 3'b100
	} asf_state_t;

endpackage

// [dv/asf_filter_ctrl_props.sv]
`timescale 1ns/1ps
module asf_filter_ctrl_props (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// Register port
	input wire logic [31:0]       regAddr,
	input wire logic [15:0]       regWdata,
	input wire logic              regWr,
	// Converter side
	input wire logic              convReset,
	input wire asf_pkg::asf_cfg_t filterCfg,
	input wire logic              modTick,
	input wire logic              resultStrobe,
	input wire logic              resultSettled
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_reset_cause;
		convReset |-> $past(regWr) && $past(regAddr) == asf_pkg::FILTER_CTRL_ADDR;
	endproperty
	a_reset_cause: assert property (p_reset_cause)
		else $error("converter reset without control write");
	property p_cfg_follow;
		convReset |=> filterCfg[13:0] == $past(regWdata[13:0], 2)
			&& filterCfg.runningAverage == ($past(regWdata[14], 2) | $past(regWdata[15], 2));
	endproperty
	a_cfg_follow: assert property (p_cfg_follow)
		else $error("filter setting does not follow write");
	property p_chop_runavg;
		filterCfg.chop |-> filterCfg.runningAverage;
	endproperty
	a_chop_runavg: assert property (p_chop_runavg)
		else $error("running average off while chopping");
	property p_quiet_warm;
		convReset |=> !resultStrobe [*8];
	endproperty
	a_quiet_warm: assert property (p_quiet_warm)
		else $error("result during start-up delay");
	property p_settle_clear;
		convReset |=> !resultSettled [*8];
	endproperty
	a_settle_clear: assert property (p_settle_clear)
		else $error("settled flag kept over restart");
	property p_settle_strobe;
		$rose(resultSettled) |-> $past(resultStrobe);
	endproperty
	a_settle_strobe: assert property (p_settle_strobe)
		else $error("settled without a result");
	property p_tick_space;
		modTick |=> !modTick [*8];
	endproperty
	a_tick_space: assert property (p_tick_space)
		else $error("modulator ticks too close");
	property p_strobe_pulse;
		resultStrobe |=> !resultStrobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse)
		else $error("result strobe too long");
endmodule

// [dv/asf_filter_ctrl_bench.sv]
`timescale 1ns/1ps
module asf_filter_ctrl_bench;
	localparam logic [31:0] CTRL = asf_pkg::FILTER_CTRL_ADDR;
	localparam logic [31:0] STAT = asf_pkg::FILTER_STAT_ADDR;
	localparam int          LP_GAP = asf_pkg::REF_CLK_HZ / asf_pkg::LP_MOD_HZ;
	logic              ref_clk;
	logic              rst_n;
	logic              regWr;
	logic              regRd;
	logic              lowPower;
	logic              curEnable;
	logic              vtEnable;
	logic [31:0]       regAddr;
	logic [15:0]       regWdata;
	logic [15:0]       regRdata;
	logic              convReset;
	logic              modTick;
	logic              resultStrobe;
	logic              resultSettled;
	asf_pkg::asf_cfg_t filterCfg;
	int                err_count;
	int                checks_done;

	asf_filter_ctrl u_asf_filter_ctrl (.ref_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .lowPower, .curEnable, .vtEnable, .convReset, .filterCfg, .modTick,
		.resultStrobe, .resultSettled);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
		d = regRdata;
	endtask

	task t_regs;
		logic [15:0] v;
		rd(CTRL, v);
		chk(v, 16'h0007);
		chk(filterCfg, 16'h0007);
		wr(CTRL, 16'h8000);
		@(posedge ref_clk);
		chk({15'h0, convReset}, 16'h0001);
		@(posedge ref_clk);
		chk(filterCfg, 16'hc000);
		rd(CTRL, v);
		chk(v, 16'h8000);
		wr(CTRL, 16'h8000);
		@(posedge ref_clk);
		chk({15'h0, convReset}, 16'h0000);
		wr(CTRL, 16'h3f85);
		repeat (2) @(posedge ref_clk);
		chk(filterCfg, 16'h3f85);
		wr(32'hffff0520, 16'h1234);
		rd(32'hffff0520, v);
		chk(v, 16'h0000);
		$display("t_regs done");
	endtask

	// Skips the first result: its tick count starts inside the start-up delay
	task t_rate(input logic [15:0] cfg, input int per, input int stl);
		int t;
		int n;
		int k;
		t = 0;
		n = 0;
		wr(CTRL, cfg);
		repeat (2) @(posedge ref_clk);
		for (k = 0; k < 60000 && resultSettled !== 1'b1; k++) begin
			@(posedge ref_clk);
			if (modTick === 1'b1) t++;
			if (resultStrobe === 1'b1) begin
				if (n > 0) chk(16'(t), 16'(per));
				n++;
				t = 0;
			end
		end
		chk(16'(n), 16'(stl));
		$display("t_rate %h done", cfg);
	endtask

	// Illegal pair on purpose: flagged, still honoured; two converters double start-up
	task t_status;
		logic [15:0] v;
		int          g;
		vtEnable <= 1'b1;
		wr(CTRL, 16'h0140);
		rd(CTRL, v);
		chk(v, 16'h0140);
		rd(STAT, v);
		chk(v, 16'h0014);
		repeat (2600) @(posedge ref_clk);
		rd(STAT, v);
		chk(v, 16'h0014);
		repeat (2400) @(posedge ref_clk);
		rd(STAT, v);
		chk(v, 16'h000c);
		lowPower <= 1'b1;
		repeat (400) @(posedge ref_clk);
		while (modTick !== 1'b1) @(posedge ref_clk);
		g = 0;
		do begin
			@(posedge ref_clk);
			g++;
		end while (modTick !== 1'b1 && g < 400);
		chk({15'h0, (g == LP_GAP || g == LP_GAP + 1)}, 16'h0001);
		lowPower <= 1'b0;
		$display("t_status done");
	endtask

	initial begin
		err_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 32'h0;
		regWdata = 16'h0;
		lowPower = 1'b0;
		curEnable = 1'b0;
		vtEnable = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs;
		curEnable <= 1'b1;
		t_rate(16'h0000, 64, 3);
		t_rate(16'h4000, 64, 4);
		t_rate(16'h8000, 195, 2);
		t_status;
		final_report;
	end

	// Tests take about 80k cycles
	initial begin
		#(95000 * 25);
		err_count++;
		final_report;
	end

	task final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
endmodule

bind asf_filter_ctrl asf_filter_ctrl_props u_asf_filter_ctrl_props (.ref_clk, .rst_n, .regAddr,
	.regWdata, .regWr, .convReset, .filterCfg, .modTick, .resultStrobe, .resultSettled);
